// *** upsr_path_selector.sv ***
/*
 * upsr_path_selector: chooses working or protect payload per circuit,
 * with AXI4-Lite provisioning. Assumes receiver inputs come from logic on
 * clk, so they are used unsynchronised.
 * Readies and valids are registered, so a read answer lags one edge and a write answer two.
 */
// Our own choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
module upsr_path_selector #(
   parameter logic [31:0] TICKS_PER_SEC = upsr_pkg::UPSR_TICKS_SEC
) (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // path receivers
   input wire upsr_pkg::upsr_path_s work_in,
   input wire upsr_pkg::upsr_path_s prot_in,
   // selected payload and status
   output logic [7:0] sel_data,
   output logic on_protect,
   // axi4-lite write
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   import upsr_pkg::*;

   // ************************************************
   // register state
   // ************************************************
   logic [2:0] ctrl, next_ctrl;
   logic [7:0] sf_thr, next_sf_thr;
   logic [7:0] sd_thr, next_sd_thr;
   logic [31:0] wtr_sec, next_wtr_sec;
   upsr_cmd_e cmd, next_cmd;
   logic aw_hold, next_aw_hold;
   logic w_hold, next_w_hold;
   logic [7:0] aw_addr, next_aw_addr;
   logic [31:0] w_data, next_w_data;
   logic [3:0] w_strb, next_w_strb;
   logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
   logic [1:0] next_bresp, next_rresp;
   logic [31:0] next_rdata;
   logic do_write, cmd_write;

   // ************************************************
   // selector state
   // ************************************************
   upsr_state_e state, next_state;
   logic [31:0] tick, next_tick;
   logic [31:0] secs, next_secs;
   logic [31:0] sw_cnt, next_sw_cnt;
   logic [7:0] next_sel_data;
   logic next_on_protect;

   // path condition: ber exponent n means rate 1e-n, smaller is worse
   logic w_sf, w_sd, p_sf, p_sd, w_bad, p_bad;
   always_comb begin
      w_sf = work_in.ber_exp <= sf_thr;
      p_sf = prot_in.ber_exp <= sf_thr;
      w_sd = ctrl[UPSR_CTRL_STS_BIT] && work_in.ber_exp <= sd_thr;
      p_sd = ctrl[UPSR_CTRL_STS_BIT] && prot_in.ber_exp <= sd_thr;
      w_bad = w_sf || w_sd;
      p_bad = p_sf || p_sd;
   end

   // write channel: address and data accepted in either order
   always_comb begin
      next_aw_hold = aw_hold;
      next_w_hold = w_hold;
      next_aw_addr = aw_addr;
      next_w_data = w_data;
      next_w_strb = w_strb;
      next_bvalid = s_axi_bvalid;
      next_bresp = s_axi_bresp;
      do_write = 1'b0;
      if (s_axi_awvalid && s_axi_awready) begin
         next_aw_hold = 1'b1;
         next_aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_w_hold = 1'b1;
         next_w_data = s_axi_wdata;
         next_w_strb = s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
         next_bvalid = 1'b0;
      end
      if (aw_hold && w_hold && !s_axi_bvalid) begin
         do_write = 1'b1;
         next_aw_hold = 1'b0;
         next_w_hold = 1'b0;
         next_bvalid = 1'b1;
         case (aw_addr)
            UPSR_CTRL_OFS, UPSR_CMD_OFS, UPSR_SF_OFS, UPSR_SD_OFS,
            UPSR_WTR_OFS: next_bresp = UPSR_RESP_OK;
            default: next_bresp = UPSR_RESP_ERR;
         endcase
      end
      // readies return once the held beat is used, so a second write may
      // wait behind an unread response; it is applied only after bready
      next_awready = !next_aw_hold;
      next_wready = !next_w_hold;
   end

   // provisioning registers; low byte lanes only where fields are narrow
   always_comb begin
      next_ctrl = ctrl;
      next_sf_thr = sf_thr;
      next_sd_thr = sd_thr;
      next_wtr_sec = wtr_sec;
      next_cmd = cmd;
      cmd_write = 1'b0;
      if (do_write && w_strb[0]) begin
         case (aw_addr)
            UPSR_CTRL_OFS: next_ctrl = w_data[2:0];
            UPSR_SF_OFS: next_sf_thr = w_data[7:0];
            UPSR_SD_OFS: next_sd_thr = w_data[7:0];
            UPSR_CMD_OFS: begin
               cmd_write = 1'b1;
               case (w_data[2:0])
                  3'h0: next_cmd = UPSR_CMD_CLEAR;
                  3'h1: next_cmd = UPSR_CMD_LOCKOUT;
                  3'h2: next_cmd = UPSR_CMD_FORCE_W;
                  3'h3: next_cmd = UPSR_CMD_FORCE_P;
                  3'h4: next_cmd = UPSR_CMD_MAN_W;
                  3'h5: next_cmd = UPSR_CMD_MAN_P;
                  default: next_cmd = cmd;
               endcase
            end
            default: ;
         endcase
      end
      if (do_write && aw_addr == UPSR_WTR_OFS) begin
         for (int b = 0; b < 4; b++) begin
            if (w_strb[b]) begin
               next_wtr_sec[8*b +: 8] = w_data[8*b +: 8];
            end
         end
      end
      // manual request dropped once its target goes bad
      if (!cmd_write) begin
         if ((cmd == UPSR_CMD_MAN_W && w_bad) ||
             (cmd == UPSR_CMD_MAN_P && p_bad)) begin
            next_cmd = UPSR_CMD_CLEAR;
         end
      end
   end

   // read channel: one beat answered the cycle after address is taken
   // arready pulses while idle; a held arvalid is taken on the next pulse
   always_comb begin
      next_arready = 1'b0;
      next_rvalid = s_axi_rvalid;
      next_rdata = s_axi_rdata;
      next_rresp = s_axi_rresp;
      if (s_axi_rvalid && s_axi_rready) begin
         next_rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         next_rvalid = 1'b1;
         next_rresp = UPSR_RESP_OK;
         next_rdata = 32'h0000_0000;
         case (s_axi_araddr)
            UPSR_CTRL_OFS: next_rdata[2:0] = ctrl;
            UPSR_CMD_OFS: next_rdata[2:0] = cmd;
            UPSR_SF_OFS: next_rdata[7:0] = sf_thr;
            UPSR_SD_OFS: next_rdata[7:0] = sd_thr;
            UPSR_WTR_OFS: next_rdata = wtr_sec;
            UPSR_STAT_OFS: next_rdata[6:0] =
               {state, p_bad, w_bad, prot_in.pdi, work_in.pdi, on_protect};
            UPSR_CNT_OFS: next_rdata = sw_cnt;
            default: next_rresp = UPSR_RESP_ERR;
         endcase
      end else if (!s_axi_rvalid && !s_axi_arready) begin
         next_arready = 1'b1;
      end
   end

   // selection: lockout, force, sf, sd, payload defect, manual, then wait-to-restore
   logic want_prot, auto_req, pdi_hit;
   always_comb begin
      next_state = state;
      next_tick = tick;
      next_secs = secs;
      // payload defect counts on the carried path only; with both paths
      // flagged and clean otherwise the choice flips every cycle
      pdi_hit = ctrl[UPSR_CTRL_PDI_BIT] && ctrl[UPSR_CTRL_STS_BIT] &&
         (on_protect ? prot_in.pdi : work_in.pdi);
      auto_req = 1'b0;
      want_prot = on_protect;
      if (cmd == UPSR_CMD_LOCKOUT) begin
         want_prot = 1'b0;
         auto_req = 1'b1;
      end else if (cmd == UPSR_CMD_FORCE_W) begin
         want_prot = 1'b0;
         auto_req = 1'b1;
      end else if (cmd == UPSR_CMD_FORCE_P) begin
         want_prot = 1'b1;
         auto_req = 1'b1;
      end else if (w_sf != p_sf) begin
         want_prot = w_sf;
         auto_req = 1'b1;
      end else if (w_sd != p_sd) begin
         want_prot = w_sd;
         auto_req = 1'b1;
      end else if (pdi_hit) begin
         want_prot = !on_protect;
         auto_req = 1'b1;
      end else if (cmd == UPSR_CMD_MAN_W && !w_bad) begin
         want_prot = 1'b0;
         auto_req = 1'b1;
      end else if (cmd == UPSR_CMD_MAN_P && !p_bad) begin
         want_prot = 1'b1;
         auto_req = 1'b1;
      end
      case (state)
         UPSR_ST_WORK: begin
            if (auto_req && want_prot) begin
               next_state = UPSR_ST_PROT;
            end
         end
         UPSR_ST_PROT: begin
            if (auto_req && !want_prot) begin
               next_state = UPSR_ST_WORK;
            end else if (!auto_req && ctrl[UPSR_CTRL_REVERT_BIT]) begin
               // cause gone: start the wait; never-revert stays here
               next_state = UPSR_ST_WTR;
               next_tick = 32'h0000_0000;
               next_secs = 32'h0000_0000;
            end
         end
         UPSR_ST_WTR: begin
            // traffic stays on protect while the wait runs
            if (auto_req) begin
               next_state = want_prot ? UPSR_ST_PROT : UPSR_ST_WORK;
            end else if (!ctrl[UPSR_CTRL_REVERT_BIT]) begin
               next_state = UPSR_ST_PROT;
            end else if (secs >= wtr_sec) begin
               next_state = UPSR_ST_WORK;
            end else if (tick >= TICKS_PER_SEC - 32'h0000_0001) begin
               next_tick = 32'h0000_0000;
               next_secs = secs + 32'h0000_0001;
            end else begin
               next_tick = tick + 32'h0000_0001;
            end
         end
         default: next_state = UPSR_ST_WORK;
      endcase
      next_on_protect = next_state != UPSR_ST_WORK;
      next_sel_data = next_on_protect ? prot_in.data : work_in.data;
      // count each change of carried path
      next_sw_cnt = sw_cnt + 32'((next_on_protect != on_protect) ? 1 : 0);
   end

   // ************************************************
   // registers
   // ************************************************
   // provisioning registers and the pending command
   // command write and manual cancel share next_cmd, the write wins
   always_ff @(posedge clk) begin
      if (!resetn) begin
         ctrl <= UPSR_CTRL_RST;
         sf_thr <= UPSR_SF_RST[7:0];
         sd_thr <= UPSR_SD_RST[7:0];
         wtr_sec <= UPSR_WTR_RST;
         cmd <= UPSR_CMD_CLEAR;
      end else begin
         ctrl <= next_ctrl;
         sf_thr <= next_sf_thr;
         sd_thr <= next_sd_thr;
         wtr_sec <= next_wtr_sec;
         cmd <= next_cmd;
      end
   end

   // bus channel registers: every axi output leaves a flip-flop
   always_ff @(posedge clk) begin
      if (!resetn) begin
         aw_hold <= 1'b0;
         w_hold <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= UPSR_RESP_OK;
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= UPSR_RESP_OK;
      end else begin
         aw_hold <= next_aw_hold;
         w_hold <= next_w_hold;
         aw_addr <= next_aw_addr;
         w_data <= next_w_data;
         w_strb <= next_w_strb;
         s_axi_awready <= next_awready;
         s_axi_wready <= next_wready;
         s_axi_bvalid <= next_bvalid;
         s_axi_bresp <= next_bresp;
         s_axi_arready <= next_arready;
         s_axi_rvalid <= next_rvalid;
         s_axi_rdata <= next_rdata;
         s_axi_rresp <= next_rresp;
      end
   end

   // selector registers; on_protect and sel_data come from next_state
   // so the carried payload and the status move on the same edge
   always_ff @(posedge clk) begin
      if (!resetn) begin
         state <= UPSR_ST_WORK;
         tick <= 32'h0000_0000;
         secs <= 32'h0000_0000;
         sw_cnt <= 32'h0000_0000;
         on_protect <= 1'b0;
         sel_data <= 8'h00;
      end else begin
         state <= next_state;
         tick <= next_tick;
         secs <= next_secs;
         sw_cnt <= next_sw_cnt;
         on_protect <= next_on_protect;
         sel_data <= next_sel_data;
      end
   end
endmodule

// *** upsr_path_selector_chk.sv ***
/* upsr_path_selector_chk: port-level assertions on the path selector.
   Assumes one clock domain, bound by name to the top module. */
`timescale 1ns/1ps
module upsr_path_selector_chk #(
   parameter logic [31:0] TICKS_PER_SEC = upsr_pkg::UPSR_TICKS_SEC
) (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // paths and selection
   input wire upsr_pkg::upsr_path_s work_in,
   input wire upsr_pkg::upsr_path_s prot_in,
   input wire logic [7:0] sel_data,
   input wire logic on_protect,
   // axi4-lite handshakes
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   import upsr_pkg::*;
   // ************************************************
   // checks
   // ************************************************
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   // path must be steady two cycles, the mux timing is not pinned down
   a_sel_work: assert property ($past(resetn) && !on_protect &&
      !$past(on_protect) |-> sel_data == $past(work_in.data))
      else $error("payload not from working path");
   a_sel_prot: assert property ($past(resetn) && on_protect &&
      $past(on_protect) |-> sel_data == $past(prot_in.data))
      else $error("payload not from protect path");
   a_reset_idle: assert property ($rose(resetn) |-> !on_protect &&
      !s_axi_bvalid && !s_axi_rvalid && sel_data == 8'h00)
      else $error("state not cleared by reset");
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
      else $error("read data dropped early");
   a_read_lat: assert property (s_axi_arvalid && s_axi_arready
      |=> s_axi_rvalid) else $error("read answer late");
   a_write_lat: assert property (s_axi_awvalid && s_axi_awready &&
      s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid)
      else $error("write answer not two cycles on");
   a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address taken while busy");
   // a beat taken closes its own channel for the next cycle
   a_aw_blocked: assert property (s_axi_awvalid && s_axi_awready
      |=> !s_axi_awready) else $error("write address taken twice");
   a_w_blocked: assert property (s_axi_wvalid && s_axi_wready
      |=> !s_axi_wready) else $error("write data taken twice");
endmodule
bind upsr_path_selector upsr_path_selector_chk #(
   .TICKS_PER_SEC(TICKS_PER_SEC)) u_chk (
   .clk(clk), .resetn(resetn), .work_in(work_in), .prot_in(prot_in),
   .sel_data(sel_data), .on_protect(on_protect),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready));

// *** upsr_path_selector_tb.sv ***
/* upsr_path_selector_tb: self-checking bench for the path selector.
   Assumes the wait unit is shortened to 4 cycles per second. */
`timescale 1ns/1ps
module upsr_path_selector_tb;
   import upsr_pkg::*;
   // ************************************************
   // signals
   // ************************************************
   logic clk = 0, resetn = 0;
   upsr_path_s work_in, prot_in;
   logic [7:0] sel_data, s_axi_awaddr = 0, s_axi_araddr = 0;
   logic on_protect, s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic s_axi_arready, s_axi_rvalid;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, st = 32'hF;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [7:0] wber = 8'hA, pber = 8'hA;
   logic wpdi = 0, ppdi = 0, eprot = 0;
   logic [7:0] pw, pp;
   int n_errors = 0, total_checks = 0, cyc = 0, ecnt = 0;
   always #4 clk = ~clk;
   upsr_path_selector #(.TICKS_PER_SEC(32'h4)) u_upsr_path_selector (
      .clk(clk), .resetn(resetn), .work_in(work_in), .prot_in(prot_in),
      .sel_data(sel_data), .on_protect(on_protect),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready));
   upsr_rx_model u_work (.clk(clk), .ber(wber), .pdi(wpdi),
      .rnd(st[7:0]), .path(work_in));
   upsr_rx_model u_prot (.clk(clk), .ber(pber), .pdi(ppdi),
      .rnd(st[15:8]), .path(prot_in));
   // ************************************************
   // helpers
   // ************************************************
   function automatic logic [31:0] xs(input logic [31:0] v);
      v ^= v << 13;
      v ^= v >> 17;
      v ^= v << 5;
      return v;
   endfunction
   // payload source and hang guard
   always @(posedge clk) begin
      st <= xs(st);
      // payload seen by the selector one edge ago, for the mux check
      pw <= work_in.data;
      pp <= prot_in.data;
      cyc++;
      if (cyc == 5000) begin
         n_errors++;
         end_sim();
      end
   end
   task automatic end_sim();
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   // address and data go out together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] er = UPSR_RESP_OK);
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      do begin
         @(posedge clk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
      end while (!s_axi_bvalid);
      chk(s_axi_bresp, er);
      s_axi_bready <= 0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e,
      input logic [1:0] er = UPSR_RESP_OK);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      do begin
         @(posedge clk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
      end while (!s_axi_rvalid);
      chk(s_axi_rdata, e);
      chk(s_axi_rresp, er);
      s_axi_rready <= 0;
   endtask
   // set path conditions, let n cycles pass, compare the active path
   task automatic step(input logic [7:0] wb, input logic [7:0] pb,
      input logic wp, input logic ep, input int n);
      wber <= wb;
      pber <= pb;
      wpdi <= wp;
      repeat (n) @(posedge clk);
      chk(on_protect, ep);
      chk(sel_data, ep ? pp : pw);
      if (ep != eprot) ecnt++;
      eprot = ep;
   endtask
   // ************************************************
   // scenarios
   // ************************************************
   initial begin
      repeat (12) @(posedge clk);
      resetn <= 1;
      rd(UPSR_CTRL_OFS, 32'h5);
      rd(UPSR_SF_OFS, UPSR_SF_RST);
      rd(UPSR_SD_OFS, UPSR_SD_RST);
      rd(UPSR_WTR_OFS, 32'd300);
      rd(UPSR_CNT_OFS, 32'h0);
      rd(8'h1C, 32'h0, UPSR_RESP_ERR);
      wr(8'h1C, 32'h1, UPSR_RESP_ERR);
      wr(UPSR_CNT_OFS, 32'h7, UPSR_RESP_ERR);
      wr(UPSR_WTR_OFS, 32'h2);
      step(8'h3, 8'hA, 0, 1, 5);
      step(8'hA, 8'hA, 0, 1, 4);
      step(8'hA, 8'hA, 0, 0, 12);
      step(8'h6, 8'hA, 0, 1, 5);
      wr(UPSR_CTRL_OFS, 32'h4);
      step(8'hA, 8'hA, 0, 1, 30);
      wr(UPSR_CMD_OFS, 32'h2);
      step(8'h3, 8'hA, 0, 0, 5);
      wr(UPSR_CMD_OFS, 32'h3);
      step(8'hA, 8'h3, 0, 1, 5);
      wr(UPSR_CMD_OFS, 32'h1);
      step(8'h3, 8'hA, 0, 0, 5);
      wr(UPSR_CMD_OFS, 32'h0);
      step(8'h3, 8'hA, 0, 1, 5);
      wr(UPSR_CMD_OFS, 32'h4);
      step(8'h3, 8'hA, 0, 1, 5);
      rd(UPSR_CMD_OFS, 32'h0);
      step(8'hA, 8'hA, 0, 1, 5);
      wr(UPSR_CMD_OFS, 32'h4);
      step(8'hA, 8'hA, 0, 0, 5);
      wr(UPSR_CMD_OFS, 32'h5);
      step(8'hA, 8'hA, 0, 1, 5);
      wr(UPSR_CMD_OFS, 32'h7);
      rd(UPSR_CMD_OFS, 32'h5);
      step(8'hA, 8'h5, 0, 0, 5);
      rd(UPSR_CMD_OFS, 32'h0);
      step(8'hA, 8'hA, 0, 0, 5);
      rd(UPSR_CNT_OFS, 32'(ecnt));
      wr(UPSR_CTRL_OFS, 32'h6);
      step(8'hA, 8'hA, 1, 1, 5);
      rd(UPSR_STAT_OFS, 32'h23);
      ppdi <= 1;
      step(8'hA, 8'hA, 0, 0, 5);
      rd(UPSR_CNT_OFS, 32'(ecnt));
      wr(UPSR_CTRL_OFS, 32'h1);
      step(8'h6, 8'hA, 0, 0, 5);
      end_sim();
   end
endmodule

// *** upsr_pkg.sv ***
/*
 * upsr_pkg: constants, command codes, states and carrier structs for the
 * path selector. Assumes one 125 MHz clock and a synchronous reset.
 */
package upsr_pkg;
   // ************************************************
   // register map
   // ************************************************
   localparam logic [7:0] UPSR_CTRL_OFS = 8'h00;
   localparam logic [7:0] UPSR_CMD_OFS = 8'h04;
   localparam logic [7:0] UPSR_SF_OFS = 8'h08;
   localparam logic [7:0] UPSR_SD_OFS = 8'h0C;
   localparam logic [7:0] UPSR_WTR_OFS = 8'h10;
   localparam logic [7:0] UPSR_STAT_OFS = 8'h14;
   localparam logic [7:0] UPSR_CNT_OFS = 8'h18;
   // ctrl fields
   localparam int UPSR_CTRL_REVERT_BIT = 0;
   localparam int UPSR_CTRL_PDI_BIT = 1;
   localparam int UPSR_CTRL_STS_BIT = 2;
   // reset values
   localparam logic [2:0] UPSR_CTRL_RST = 3'h5;
   localparam logic [31:0] UPSR_SF_RST = 32'h0000_0004;
   localparam logic [31:0] UPSR_SD_RST = 32'h0000_0007;
   // time constants and bus response codes
   localparam int UPSR_CLK_MHZ = 125;
   localparam int UPSR_WTR_MIN = 5;
   localparam int UPSR_WTR_SEC = UPSR_WTR_MIN * 60;
   localparam logic [31:0] UPSR_WTR_RST = 32'(UPSR_WTR_SEC);
   localparam logic [31:0] UPSR_TICKS_SEC = 32'(UPSR_CLK_MHZ * 1000000);
   localparam logic [1:0] UPSR_RESP_OK = 2'h0;
   localparam logic [1:0] UPSR_RESP_ERR = 2'h2;

   // external commands
   typedef enum logic [2:0] {
      UPSR_CMD_CLEAR = 3'b000,
      UPSR_CMD_LOCKOUT = 3'b001,
      UPSR_CMD_FORCE_W = 3'b010,
      UPSR_CMD_FORCE_P = 3'b011,
      UPSR_CMD_MAN_W = 3'b100,
      UPSR_CMD_MAN_P = 3'b101
   } upsr_cmd_e;

   // selector state
   typedef enum logic [1:0] {
      UPSR_ST_WORK = 2'b00,
      UPSR_ST_PROT = 2'b01,
      UPSR_ST_WTR = 2'b10
   } upsr_state_e;

   // per-path condition from a receiver
   typedef struct packed {
      logic [7:0] ber_exp;
      logic pdi;
      logic [7:0] data;
   } upsr_path_s;
endpackage

// *** upsr_rx_model.sv ***
/* upsr_rx_model: one remote path receiver feeding the selector.
   Assumes condition and payload are driven from the bench clock. */
`timescale 1ns/1ps
module upsr_rx_model (
   // clock
   input wire logic clk,
   // condition and payload
   input wire logic [7:0] ber,
   input wire logic pdi,
   input wire logic [7:0] rnd,
   // to the selector
   output upsr_pkg::upsr_path_s path
);
   import upsr_pkg::*;
   // ************************************************
   // receiver
   // ************************************************
   // payload changes every cycle so a stuck mux shows
   always_ff @(posedge clk) begin
      path <= '{ber_exp: ber, pdi: pdi, data: rnd};
   end
endmodule
